/* rtl/sfs_flash_dev.sv */
// Serial flash device end: security register program/read and status reads.
// Assumes SPI mode 0 from the host; link pins are sampled by the local clock.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "sfs_map.svh"

////////////////////////////////////////////////////////////////////////////////
module sfs_flash_dev #(
  parameter int PROG_CYCLES = `SFS_PROG_CYC
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         nrst,
  // Link
  sfs_link_if.device        link,
  // Status write path (outside this block's commands)
  input  wire logic         stat_wr,
  input  wire logic [7:0]   stat_wr_data,
  input  wire logic [7:0]   stat2_in,
  // Observation
  output logic              busy,
  output logic [7:0]        status_byte_one
);
  import sfs_pkg::*;

  typedef enum logic [2:0] {
    SFS_DS_OP   = 3'b000,
    SFS_DS_ADDR = 3'b001,
    SFS_DS_DUMY = 3'b011,
    SFS_DS_DATA = 3'b010,
    SFS_DS_STAT = 3'b110,
    SFS_DS_IDLE = 3'b100
  } sfs_dstate_e;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: first stage read only by second
  logic [2:0] sync1;          // cs_n, sclk, si first stage
  logic [2:0] sync2;          // Second stage
  logic       sclk_d;         // Previous synced sclk
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sync1  <= 3'h7;
      sync2  <= 3'h7;
      sclk_d <= 1'b0;
    end else begin
      sync1  <= {link.cs_n, link.sclk, link.si};
      sync2  <= sync1;
      sclk_d <= sync2[1];
    end
  end
  wire cs_act = !sync2[2];
  wire rise   = cs_act && sync2[1] && !sclk_d;
  wire fall   = cs_act && !sync2[1] && sclk_d;
  wire si_s   = sync2[0];

  ////////////////////////////////////////////////////////////////////////////
  // Storage: page buffer and three security pages
  logic [7:0] pbuf  [`SFS_BUF_BYTES];   // Shared page buffer
  logic [7:0] secmem[4*`SFS_BUF_BYTES]; // Index 0..3FF, pages 1..3 in use

  // Command state
  sfs_dstate_e st, next_st;
  logic [7:0]  shreg, next_shreg;   // Input shift
  logic [2:0]  bitn, next_bitn;     // Bit within byte
  logic [1:0]  abytes, next_abytes; // Address bytes seen
  logic [7:0]  op, next_op;
  logic [23:0] addr, next_addr;
  logic [7:0]  obyte, next_obyte;   // Byte being shifted out
  logic        so_q, next_so_q;
  logic        oe_n, next_oe_n;
  logic        write_enable_latch, next_wel;
  logic [5:0]  stat_hi, next_stat_hi; // Bits 7..2 of status byte one
  logic [8:0]  nload, next_nload;   // Bytes loaded into buffer
  logic [31:0] pcnt, next_pcnt;     // Program timer
  logic        pbusy, next_pbusy;
  logic        cs_was, next_cs_was;
  logic        buf_we;
  logic [7:0]  buf_wa;
  logic        pdone;
  logic        buf_clr;             // Program or read command begins while not busy
  logic [1:0]  ppg, next_ppg;       // Page latched at program launch
  logic [`SFS_BUF_BYTES-1:0] loaded; // Buffer bytes loaded by this command

  assign busy            = pbusy;
  assign status_byte_one = {stat_hi[5:0], write_enable_latch, pbusy};
  assign link.so         = so_q;
  assign link.so_oe_n    = oe_n;

  // Page decode and lock check for program
  wire [1:0] pg      = addr[9:8];
  wire page_ok       = addr[23:16] == `SFS_ADDR_HI && addr[15:8] >= `SFS_PAGE_FIRST
                       && addr[15:8] <= `SFS_PAGE_LAST;
  wire page_locked   = stat2_in[`SFS_LOCK_LSB + pg - 2'h1];

  // Byte that would stream out for the current read/status command
  function automatic logic [7:0] out_src(input logic [7:0] o, input logic [23:0] a,
                                         input logic [7:0] s1, input logic [7:0] s2);
    case (o)
      `SFS_OP_RD_STAT1: out_src = s1;
      `SFS_OP_RD_STAT2: out_src = s2;
      default:          out_src = secmem[a[9:0]];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the command engine
  always_comb begin
    next_st = st; next_shreg = shreg; next_bitn = bitn; next_abytes = abytes;
    next_op = op; next_addr = addr; next_obyte = obyte; next_so_q = so_q;
    next_oe_n = oe_n; next_wel = write_enable_latch; next_stat_hi = stat_hi; next_nload = nload;
    next_pcnt = pcnt; next_pbusy = pbusy; next_cs_was = cs_act;
    next_ppg = ppg;
    buf_we = 1'b0; buf_wa = addr[7:0]; pdone = 1'b0;
    buf_clr = 1'b0;
    // Self-timed program, status reads still served meanwhile
    if (pbusy) begin
      if (pcnt == 32'h0) begin
        next_pbusy = 1'b0;
        pdone      = 1'b1;
        next_wel   = 1'b0;
      end else begin
        next_pcnt = pcnt - 32'h1;
      end
    end
    // Status write moves bits 7..2 and clears the latch
    if (stat_wr && write_enable_latch && !pbusy) begin
      next_stat_hi = stat_wr_data[7:2];
      next_wel     = 1'b0;
    end
    if (!cs_act) begin
      // Release: tristate at any bit; maybe launch program
      next_oe_n = 1'b1;
      next_st   = SFS_DS_OP;
      next_bitn = 3'h0;
      next_abytes = 2'h0;
      if (cs_was && op == `SFS_OP_PROG_SEC && st == SFS_DS_DATA) begin
        if (bitn == 3'h0 && nload != 9'h0 && write_enable_latch && page_ok && !page_locked && !pbusy) begin
          next_pbusy = 1'b1;
          next_pcnt  = 32'(PROG_CYCLES - 1);
          next_ppg   = pg;  // A later read may move addr while busy
        end else if (write_enable_latch && !pbusy) begin
          next_wel = 1'b0;
        end
      end
      if (cs_was) next_op = 8'h00;
    end else if (rise) begin
      next_shreg = {shreg[6:0], si_s};
      next_bitn  = bitn + 3'h1;
      if (bitn == `SFS_LAST_BIT) begin
        case (st)
          SFS_DS_OP: begin
            next_op = {shreg[6:0], si_s};
            case ({shreg[6:0], si_s})
              `SFS_OP_WREN:      begin if (!pbusy) next_wel = 1'b1; next_st = SFS_DS_IDLE; end
              `SFS_OP_PROG_SEC,
              `SFS_OP_READ_SEC:  begin
                next_st    = SFS_DS_ADDR;
                next_nload = 9'h0;
                buf_clr    = !pbusy;  // Keep a pending commit's bytes while busy
              end
              `SFS_OP_RD_STAT1,
              `SFS_OP_RD_STAT2:  next_st = SFS_DS_STAT;
              default:           next_st = SFS_DS_IDLE;
            endcase
          end
          SFS_DS_ADDR: begin
            next_addr   = {addr[15:0], shreg[6:0], si_s};
            next_abytes = abytes + 2'h1;
            if (abytes == 2'(`SFS_ADDR_BYTES - 3'h1))
              next_st = (op == `SFS_OP_READ_SEC) ? SFS_DS_DUMY : SFS_DS_DATA;
          end
          SFS_DS_DUMY: next_st = SFS_DS_DATA;
          SFS_DS_DATA: begin
            if (op == `SFS_OP_PROG_SEC && !pbusy) begin
              buf_we     = 1'b1;
              next_addr  = {addr[23:8], addr[7:0] + 8'h01};
              if (nload != 9'(`SFS_BUF_BYTES)) next_nload = nload + 9'h1;
            end
          end
          default: next_st = st;
        endcase
      end
    end else if (fall) begin
      // Output changes on falling edge
      if (st == SFS_DS_STAT || (st == SFS_DS_DATA && op == `SFS_OP_READ_SEC)) begin
        if (bitn == 3'h0) begin
          // Fresh byte each time round
          next_obyte = out_src(op, addr, status_byte_one, stat2_in);
          next_so_q  = next_obyte[7];
          if (st == SFS_DS_DATA)
            next_addr = {14'h0, addr[9:0] == `SFS_SEC_WRAP ? 10'h0 : addr[9:0] + 10'h1};
        end else begin
          next_so_q = obyte[3'h7 - bitn];
        end
        next_oe_n = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers of the command engine
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st <= SFS_DS_OP; shreg <= 8'h00; bitn <= 3'h0; abytes <= 2'h0;
      op <= 8'h00; addr <= 24'h000000; obyte <= 8'h00; so_q <= 1'b0;
      oe_n <= 1'b1; write_enable_latch <= 1'b0; stat_hi <= 6'h00; nload <= 9'h000;
      pcnt <= 32'h0; pbusy <= 1'b0; cs_was <= 1'b0;
      ppg <= 2'h0;
    end else begin
      st <= next_st; shreg <= next_shreg; bitn <= next_bitn; abytes <= next_abytes;
      op <= next_op; addr <= next_addr; obyte <= next_obyte; so_q <= next_so_q;
      oe_n <= next_oe_n; write_enable_latch <= next_wel; stat_hi <= next_stat_hi; nload <= next_nload;
      pcnt <= next_pcnt; pbusy <= next_pbusy; cs_was <= next_cs_was;
      ppg <= next_ppg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer load and commit to the selected page at end of program
  // Only loaded bytes are committed; the page has no defined content before
  always_ff @(posedge clock) begin
    if (buf_we) pbuf[buf_wa] <= {shreg[6:0], si_s};
    if (buf_clr) begin
      loaded <= '0;
    end else if (buf_we) begin
      loaded[buf_wa] <= 1'b1;
    end
    if (pdone) begin
      for (int i = 0; i < `SFS_BUF_BYTES; i++) begin
        if (loaded[i]) secmem[{ppg, i[7:0]}] <= pbuf[i];
      end
    end
  end
endmodule

/* rtl/sfs_link_if.sv */
// SPI link between flash device end and host end.
// Assumes the bench joins both modports and resolves the data line.
`timescale 1ns/1ps
interface sfs_link_if;
  logic cs_n;     // Chip select, active low
  logic sclk;     // Serial clock from host
  logic si;       // Host to device data
  logic so;       // Device to host data
  logic so_oe_n;  // Device drives so while low
  modport device (input cs_n, input sclk, input si, output so, output so_oe_n);
  modport host   (output cs_n, output sclk, output si, input so, input so_oe_n);
endinterface

/* rtl/sfs_map.svh */
// Constants for the serial flash security register and status command block.
// Assumes inclusion by both ends; definitions only.
`ifndef SFS_MAP_SVH
`define SFS_MAP_SVH
`define SFS_OP_WREN      8'h06
`define SFS_OP_PROG_SEC  8'h42
`define SFS_OP_READ_SEC  8'h48
`define SFS_OP_RD_STAT1  8'h05
`define SFS_OP_RD_STAT2  8'h35
`define SFS_ADDR_HI      8'h00
`define SFS_PAGE_FIRST   8'h01
`define SFS_PAGE_LAST    8'h03
`define SFS_ADDR_BYTES   3'h3
`define SFS_LAST_BIT     3'h7
`define SFS_SEC_WRAP     10'h3FF
`define SFS_BUF_BYTES    256
`define SFS_STAT1_RESET  8'h00
`define SFS_STAT2_RESET  8'h00
`define SFS_BIT_WEL      1
`define SFS_BIT_BUSY     0
`define SFS_PROG_NS      1000
`define SFS_CLK_MHZ      200
`define SFS_PROG_CYC     ((`SFS_PROG_NS * `SFS_CLK_MHZ) / 1000)
`define SFS_LOCK_LSB     3
`define SFS_HALF_DIV     8'h0C
`endif

/* rtl/sfs_pkg.sv */
// Types shared by both ends of the serial flash command link.
// Assumes sfs_map.svh for all numeric constants.
package sfs_pkg;
  typedef logic [7:0] sfs_byte_t;
  typedef logic [23:0] sfs_addr_t;
  // Host command kinds
  typedef enum logic [2:0] {
    SFS_CMD_WREN = 3'h0,
    SFS_CMD_PROG = 3'h1,
    SFS_CMD_READ = 3'h2,
    SFS_CMD_ST1  = 3'h3,
    SFS_CMD_ST2  = 3'h4
  } sfs_cmd_e;
endpackage

/* rtl/sfs_spi_host.sv */
// SPI host end: issues write enable, program, read and status commands.
// Assumes user pulses start for one cycle while ready is high.
`timescale 1ns/1ps
`include "sfs_map.svh"

module sfs_spi_host (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              nrst,
  // Link
  sfs_link_if.host               link,
  // User command
  input  wire logic              start,
  input  wire sfs_pkg::sfs_cmd_e cmd,
  input  wire logic [23:0]       addr,
  input  wire logic [7:0]        wdata,
  input  wire logic [8:0]        nbytes,
  output logic                   ready,
  output logic                   rvalid,
  output logic [7:0]             rdata
);
  import sfs_pkg::*;

  typedef enum logic [1:0] {
    SFS_HS_IDLE = 2'b00, SFS_HS_SHIFT = 2'b01, SFS_HS_DONE = 2'b11
  } sfs_hstate_e;

  ////////////////////////////////////////////////////////////////////////////
  // Second stage only feeds logic
  logic so1, so2;
  always_ff @(posedge clock) begin
    if (!nrst) begin so1 <= 1'b0; so2 <= 1'b0; end
    else begin so1 <= link.so; so2 <= so1; end
  end

  sfs_hstate_e st, next_st;
  logic [7:0]  div, next_div;       // Half-period count
  logic        sck, next_sck;
  logic        csn, next_csn;
  logic [39:0] tx, next_tx;         // Opcode, address, dummy or write byte
  logic [5:0]  hdr, next_hdr;       // Header bits left
  logic [11:0] dbits, next_dbits;   // Data bits left
  logic [7:0]  rx, next_rx;
  logic [2:0]  rb, next_rb;
  logic        rv, next_rv;
  logic [7:0]  rd, next_rd;
  logic        is_rd, next_is_rd;

  assign link.sclk = sck;
  assign link.cs_n = csn;
  assign link.si   = tx[39];
  assign ready     = (st == SFS_HS_IDLE);
  assign rvalid    = rv;
  assign rdata     = rd;

  ////////////////////////////////////////////////////////////////////////////
  // Build the frame and walk bits; mode 0, sample on rise
  always_comb begin
    next_st = st; next_div = div; next_sck = sck; next_csn = csn; next_tx = tx;
    next_hdr = hdr; next_dbits = dbits; next_rx = rx; next_rb = rb;
    next_rv = 1'b0; next_rd = rd; next_is_rd = is_rd;
    case (st)
      SFS_HS_IDLE: begin
        if (start) begin
          next_csn = 1'b0; next_div = `SFS_HALF_DIV; next_rb = 3'h0;
          next_st  = SFS_HS_SHIFT; next_is_rd = 1'b0; next_dbits = 12'h0;
          case (cmd)
            SFS_CMD_WREN: begin next_tx = {`SFS_OP_WREN, 32'h0}; next_hdr = 6'd8; end
            SFS_CMD_PROG: begin
              next_tx = {`SFS_OP_PROG_SEC, addr, wdata}; next_hdr = 6'd40; end
            SFS_CMD_READ: begin
              next_tx = {`SFS_OP_READ_SEC, addr, 8'h00}; next_hdr = 6'd40;
              next_is_rd = 1'b1; next_dbits = {nbytes, 3'h0}; end
            SFS_CMD_ST1: begin
              next_tx = {`SFS_OP_RD_STAT1, 32'h0}; next_hdr = 6'd8;
              next_is_rd = 1'b1; next_dbits = {nbytes, 3'h0}; end
            default: begin
              next_tx = {`SFS_OP_RD_STAT2, 32'h0}; next_hdr = 6'd8;
              next_is_rd = 1'b1; next_dbits = {nbytes, 3'h0}; end
          endcase
        end
      end
      SFS_HS_SHIFT: begin
        if (div != 8'h00) next_div = div - 8'h01;
        else begin
          next_div = `SFS_HALF_DIV;
          next_sck = !sck;
          if (!sck) begin
            // Rising edge: capture read data past the header
            if (hdr == 6'd0 && is_rd) begin
              next_rx = {rx[6:0], so2};
              next_rb = rb + 3'h1;
              if (rb == `SFS_LAST_BIT) begin next_rv = 1'b1; next_rd = {rx[6:0], so2}; end
            end
          end else begin
            // Falling edge: advance
            if (hdr != 6'd0) begin
              next_hdr = hdr - 6'd1;
              next_tx  = {tx[38:0], 1'b0};
              if (hdr == 6'd1 && !is_rd) next_st = SFS_HS_DONE;
            end else if (dbits > 12'h1) next_dbits = dbits - 12'h1;
            else next_st = SFS_HS_DONE;
          end
        end
      end
      SFS_HS_DONE: begin
        if (div != 8'h00) next_div = div - 8'h01;
        else begin next_csn = 1'b1; next_st = SFS_HS_IDLE; end
      end
      default: next_st = SFS_HS_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st <= SFS_HS_IDLE; div <= 8'h00; sck <= 1'b0; csn <= 1'b1; tx <= 40'h0;
      hdr <= 6'd0; dbits <= 12'h0; rx <= 8'h00; rb <= 3'h0; rv <= 1'b0;
      rd <= 8'h00; is_rd <= 1'b0;
    end else begin
      st <= next_st; div <= next_div; sck <= next_sck; csn <= next_csn; tx <= next_tx;
      hdr <= next_hdr; dbits <= next_dbits; rx <= next_rx; rb <= next_rb; rv <= next_rv;
      rd <= next_rd; is_rd <= next_is_rd;
    end
  end
endmodule

/* testbench/sfs_link_chk.sv */
// Checker for the serial flash link joining the host end to the device end.
// Assumes plain link signals on the shared clock; instanced beside the link.
`timescale 1ns/1ps
`include "sfs_map.svh"

module sfs_link_chk (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Link
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic si,
  input  wire logic so,
  input  wire logic so_oe_n
);
  logic       sclk_q;    // Link clock one cycle ago
  logic [7:0] cnt;       // Link clock rises in this frame
  logic [7:0] op;        // Opcode gathered from the first byte
  logic [7:0] next_cnt;  // Next rise count
  logic [7:0] next_op;   // Next opcode
  logic       is_stat;   // Frame is a status read

  assign is_stat = (op == `SFS_OP_RD_STAT1) || (op == `SFS_OP_RD_STAT2);

  //////////////////////////////////////////////////////////////////////////////
  // Count rises per frame; saturate so that long status reads never wrap
  always_comb begin
    next_cnt = cnt;
    next_op  = op;
    if (cs_n) begin
      next_cnt = 8'h00;
      next_op  = 8'h00;
    end else if (sclk && !sclk_q) begin
      if (cnt != 8'hFF) next_cnt = cnt + 8'h01;
      if (cnt < 8'h08) next_op = {op[6:0], si};
    end
  end

  // Register the frame tracker
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sclk_q <= 1'b0;
      cnt    <= 8'h00;
      op     <= 8'h00;
    end else begin
      sclk_q <= sclk;
      cnt    <= next_cnt;
      op     <= next_op;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_opcode_quiet: assert property (!cs_n && cnt < 8'h08 |-> so_oe_n)
    else $error("device drove data during the opcode");
  a_read_header_quiet: assert property (
    !cs_n && op == `SFS_OP_READ_SEC && cnt < 8'h28 |-> so_oe_n)
    else $error("device drove data before the dummy byte ended");
  a_read_data_drive: assert property (
    !cs_n && op == `SFS_OP_READ_SEC && cnt >= 8'h29 |-> !so_oe_n)
    else $error("device silent during read data");
  a_status_drive: assert property (!cs_n && is_stat && cnt >= 8'h09 |-> !so_oe_n)
    else $error("device silent during status read");
  a_other_quiet: assert property (
    !cs_n && cnt >= 8'h08 && !is_stat && op != `SFS_OP_READ_SEC |-> so_oe_n)
    else $error("device drove data on a command without output");
  a_data_steady: assert property (!cs_n && !so_oe_n && sclk && $past(sclk)
    |-> $stable(so))
    else $error("serial output moved while link clock high");
  a_release_hiz: assert property ($rose(cs_n) |-> ##[1:5] so_oe_n)
    else $error("serial output not released after deselect");
  a_idle_hiz: assert property (cs_n [*6] |-> so_oe_n)
    else $error("serial output driven while deselected");
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("link clock running outside a frame");
  a_sclk_half: assert property ($rose(sclk) |=> sclk [*8])
    else $error("link clock high phase too short");

  c_read_data: cover property (op == `SFS_OP_READ_SEC && cnt == 8'h29);
  c_status_loop: cover property (op == `SFS_OP_RD_STAT1 && cnt == 8'h11);
  c_program_end: cover property (op == `SFS_OP_PROG_SEC && $rose(cs_n));
endmodule

/* testbench/testbench.sv */
// Self-checking bench: host end and device end joined over the link.
// Assumes the host user port and device status inputs; no external memory.
`timescale 1ns/1ps
`include "sfs_map.svh"

module testbench;
  import sfs_pkg::*;
  logic              clock = 1'b0;      // 200 MHz system clock
  logic              nrst = 1'b0;       // Synchronous reset
  logic              start = 1'b0;      // Host command pulse
  sfs_cmd_e          cmd = SFS_CMD_WREN;
  logic [23:0]       addr = 24'h000000;
  logic [7:0]        wdata = 8'h00;
  logic [8:0]        nbytes = 9'h001;
  logic              ready, rvalid, busy;
  logic [7:0]        rdata, status_byte_one;
  logic              stat_wr = 1'b0;    // Status write pulse
  logic [7:0]        stat_wr_data = 8'h00;
  logic [7:0]        stat2_in = 8'h42;  // Status byte two level, no page locked
  logic [7:0]        got[$];            // Bytes returned by the host
  int                stamp[$];          // Cycle of each returned byte
  int                cyc = 0;
  int                num_errors = 0;
  int                tests_run = 0;
  logic [23:0]       pa[3] = '{24'h000105, 24'h000205, 24'h0003FF};
  logic [7:0]        pd[3] = '{8'h5A, 8'hA5, 8'hC3};

  always #2.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  // Collect on the falling edge so the pulse is settled
  always @(negedge clock) if (rvalid === 1'b1) begin
    got.push_back(rdata);
    stamp.push_back(cyc);
  end

  sfs_link_if u_sfs_link_if ();
  sfs_flash_dev #(.PROG_CYCLES(600)) u_sfs_flash_dev (
    .clock(clock), .nrst(nrst), .link(u_sfs_link_if.device), .stat_wr(stat_wr),
    .stat_wr_data(stat_wr_data), .stat2_in(stat2_in), .busy(busy),
    .status_byte_one(status_byte_one));
  sfs_spi_host u_sfs_spi_host (
    .clock(clock), .nrst(nrst), .link(u_sfs_link_if.host), .start(start), .cmd(cmd),
    .addr(addr), .wdata(wdata), .nbytes(nbytes), .ready(ready), .rvalid(rvalid),
    .rdata(rdata));
  sfs_link_chk u_sfs_link_chk (
    .clock(clock), .nrst(nrst), .cs_n(u_sfs_link_if.cs_n), .sclk(u_sfs_link_if.sclk),
    .si(u_sfs_link_if.si), .so(u_sfs_link_if.so), .so_oe_n(u_sfs_link_if.so_oe_n));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_ready();
    int w;
    w = 0;
    do begin
      @(negedge clock);
      w++;
    end while (ready !== 1'b1 && w < 20000);
    if (w >= 20000) check(16'h0000, 16'h0001);
  endtask

  // One host command; a frame of three read bytes is about 1700 cycles
  task automatic run(input sfs_cmd_e c, input logic [23:0] a, input logic [7:0] d,
                     input logic [8:0] n);
    wait_ready();
    got.delete();
    stamp.delete();
    @(posedge clock);
    start  <= 1'b1;
    cmd    <= c;
    addr   <= a;
    wdata  <= d;
    nbytes <= n;
    @(posedge clock);
    start <= 1'b0;
    wait_ready();
  endtask

  task automatic stat_write(input logic [7:0] v);
    @(posedge clock);
    stat_wr      <= 1'b1;
    stat_wr_data <= v;
    @(posedge clock);
    stat_wr <= 1'b0;
    repeat (2) @(negedge clock);
  endtask

  // Program time outlasts a short status frame, so busy is seen on the link
  task automatic wait_idle();
    int w;
    w = 0;
    while (busy !== 1'b0 && w < 2000) begin
      @(negedge clock);
      w++;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs about 19000 cycles
  initial begin
    repeat (80000) @(posedge clock);
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    @(negedge clock);
    check(status_byte_one, 8'h00);
    check(u_sfs_link_if.so_oe_n, 1'b1);
    // Status writes need the latch and clear it again
    run(SFS_CMD_WREN, 24'h000000, 8'h00, 9'h001);
    stat_write(8'hFF);
    check(status_byte_one, 8'hFC);
    run(SFS_CMD_ST1, 24'h000000, 8'h00, 9'h002);
    check(got[0], 8'hFC);
    check(got[1], 8'hFC);
    run(SFS_CMD_ST2, 24'h000000, 8'h00, 9'h002);
    check(got[0], 8'h42);
    check(got[1], 8'h42);
    $display("status reads done");
    run(SFS_CMD_WREN, 24'h000000, 8'h00, 9'h001);
    stat_write(8'hA8);
    // Latch set again so that the mid-stream write is taken
    run(SFS_CMD_WREN, 24'h000000, 8'h00, 9'h001);
    check(status_byte_one, 8'hAA);
    // Change status in mid-stream; the third repeat must show it
    fork
      run(SFS_CMD_ST1, 24'h000000, 8'h00, 9'h003);
      begin
        repeat (520) @(posedge clock);
        stat_wr      <= 1'b1;
        stat_wr_data <= 8'h54;
        @(posedge clock);
        stat_wr <= 1'b0;
      end
    join
    check(got[0], 8'hAA);
    check(got[2], 8'h54);
    $display("fresh status done");
    // Program without the latch set must not start
    run(SFS_CMD_PROG, 24'h000105, 8'h00, 9'h001);
    repeat (8) @(negedge clock);
    check(busy, 1'b0);
    for (int i = 0; i < 3; i++) begin
      run(SFS_CMD_WREN, 24'h000000, 8'h00, 9'h001);
      check(status_byte_one, 8'h56);
      run(SFS_CMD_PROG, pa[i], pd[i], 9'h001);
      repeat (8) @(negedge clock);
      check(busy, 1'b1);
      run(SFS_CMD_ST1, 24'h000000, 8'h00, 9'h001);
      check(got[0] & 8'h01, 8'h01);
      wait_idle();
      check(status_byte_one, 8'h54);
    end
    for (int i = 0; i < 3; i++) begin
      run(SFS_CMD_READ, pa[i], 8'h00, 9'h001);
      check(got[0], pd[i]);
    end
    $display("program and read done");
    // Wrap from the last location with no stretch between bytes
    run(SFS_CMD_READ, 24'h0003FF, 8'h00, 9'h003);
    check(got[0], 8'hC3);
    check(16'(stamp[1] - stamp[0]), 16'(16 * (`SFS_HALF_DIV + 1)));
    check(16'(stamp[2] - stamp[1]), 16'(16 * (`SFS_HALF_DIV + 1)));
    // Locked page and a page outside the window are both refused
    stat2_in <= 8'h20;
    run(SFS_CMD_WREN, 24'h000000, 8'h00, 9'h001);
    run(SFS_CMD_PROG, 24'h0003FF, 8'h00, 9'h001);
    repeat (8) @(negedge clock);
    check(busy, 1'b0);
    check(status_byte_one, 8'h54);
    run(SFS_CMD_READ, 24'h0003FF, 8'h00, 9'h001);
    check(got[0], 8'hC3);
    run(SFS_CMD_WREN, 24'h000000, 8'h00, 9'h001);
    run(SFS_CMD_PROG, 24'h000005, 8'h00, 9'h001);
    repeat (8) @(negedge clock);
    check(busy, 1'b0);
    check(status_byte_one, 8'h54);
    $display("refusals done");
    end_of_test();
  end
endmodule
